// *** inc/pmr_pkg.sv ***
// Purpose: Shared constants and types of the power mode and reset controller.
// Assumes: APB with 32-bit data; one aligned word per register.
// Notes: Offsets are byte addresses.
package pmr_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] PMR_OFS_CTRL = 8'h00;
  localparam logic [7:0] PMR_OFS_CMD = 8'h04;
  localparam logic [7:0] PMR_OFS_SWRST = 8'h08;
  localparam logic [7:0] PMR_OFS_STATUS = 8'h0c;

  localparam logic [31:0] PMR_CTRL_RST = 32'h0000_0420;
  localparam logic [31:0] PMR_CTRL_WMASK = 32'h001f_7fff;

  // Soft reset key words, first then second.
  localparam logic [31:0] PMR_KEY_FIRST = 32'hcafe_abab;
  localparam logic [31:0] PMR_KEY_SECOND = 32'hcdcd_beef;

  // Command register bit positions.
  localparam int PMR_CMD_SLEEP_BIT = 0;
  localparam int PMR_CMD_DEEP_BIT = 1;

  // Core threshold code that selects 1.05 V.
  localparam logic [3:0] PMR_CORE_THRESH_RST = 4'h2;

  // Slow crystal mode codes.
  localparam logic [1:0] PMR_LFX_OFF = 2'h0;
  localparam logic [1:0] PMR_LFX_CRYSTAL = 2'h1;
  localparam logic [1:0] PMR_LFX_SQUARE = 2'h2;
  localparam logic [1:0] PMR_LFX_SINE = 2'h3;

  // Number of pin inputs that pass the synchroniser.
  localparam int PMR_NSYNC = 8;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [2:0] {
    MODE_ACTIVE_RC,
    MODE_ACTIVE_XTAL,
    MODE_SLEEP,
    MODE_DEEP_SLEEP,
    MODE_DISABLED
  } pmr_mode_t;

  typedef struct packed {
    logic [10:0] rsvd_hi;
    logic [2:0] retain_banks;
    logic [1:0] rc_trim;
    logic rsvd_lo;
    logic cfg_loaded;
    logic [1:0] slow_xtal_mode;
    logic sleep_clk_xtal;
    logic vcc_keep_charged;
    logic sleep_disable;
    logic radio_thresh_hi;
    logic [3:0] core_thresh;
    logic [3:0] batt_thresh;
  } pmr_ctrl_t;

  typedef struct packed {
    logic amp_en;
    logic load_cap_en;
    logic clk_en;
  } pmr_lfx_t;

endpackage : pmr_pkg

// *** core/pmr_sync.sv ***
// Purpose: Two-flop synchroniser for a group of pin levels.
// Assumes: Inputs are levels from outside the clock domain.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/100ps
`default_nettype none
module pmr_sync
  import pmr_pkg::*;
#(
  parameter int W = PMR_NSYNC
)
(
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST,
  // Levels
  input wire logic [W-1:0] D,
  output logic [W-1:0] Q
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;

  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      always_ff @(posedge MCLK)
      begin
        if (RST)
        begin
          meta_reg[i] <= 1'b0;
          sync_reg[i] <= 1'b0;
        end
        else
        begin
          meta_reg[i] <= D[i];
          sync_reg[i] <= meta_reg[i];
        end
      end
    end
  endgenerate

  assign Q = sync_reg;

endmodule : pmr_sync
`default_nettype wire

// *** core/pmr_ctrl.sv ***
// Purpose: Power mode, supply monitor routing, reset and sleep clock control.
// Assumes: MCLK is the always-on clock; RST is the full power-on reset.
// Notes: APB slave answers with one wait state; outputs are registered.
//
// The implementer's own choices: the APB register port and the address map.
`timescale 1ns/100ps
`default_nettype none
module pmr_ctrl
  import pmr_pkg::*;
(
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Pins and analog comparators
  input wire logic ENABLE,
  input wire logic STEPUP_DETECT,
  input wire logic BATT_RAIL_OK,
  input wire logic CORE_RAIL_OK,
  input wire logic RADIO_RAIL_OK,
  input wire logic CORE_POR,
  input wire logic CORE_SUPPLY_LOW,
  input wire logic WAKE_PAD,
  // Processor and timer requests
  input wire logic WATCHDOG_REQ,
  input wire logic RADIO_REQ,
  input wire logic XTAL_REQ,
  input wire logic CPU_IDLE,
  input wire logic ENOUGH_TIME,
  input wire logic SLEEP_TIMER_EXPIRED,
  // Mode and domain control
  output logic [2:0] MODE,
  output logic CORE_RESET,
  output logic PADS_HIZ,
  output logic CPU_POWER_EN,
  output logic CPU_HALT,
  output logic CONVERTER_EN,
  output logic VCC_CHARGE_EN,
  output logic FAST_RC_EN,
  output logic XTAL_EN,
  output logic [2:0] RETAIN_BANKS,
  // Supply monitor
  output logic BATT_MON_ON_CORE_RAIL,
  output logic [3:0] BATT_THRESH,
  output logic [3:0] CORE_THRESH,
  output logic RADIO_THRESH_HI,
  output logic SUPPLY_LOW_EVENT,
  // Clock control
  output logic PMCLK_HALF,
  output logic PMCLK_FROM_LP_RC,
  output logic [1:0] SLOW_RC_TRIM,
  output logic SLOW_RC_RELAXED,
  output logic SLOW_RC_CALIB_EN,
  output logic SLOW_XTAL_AMP_EN,
  output logic SLOW_XTAL_LOAD_CAP_EN,
  output logic SLOW_XTAL_CLK_EN
);

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  function automatic pmr_lfx_t lfx_decode(input logic [1:0] m);
    pmr_lfx_t r;
    r.amp_en = (m == PMR_LFX_CRYSTAL) || (m == PMR_LFX_SINE);
    r.load_cap_en = (m == PMR_LFX_CRYSTAL);
    r.clk_en = (m != PMR_LFX_OFF);
    return r;
  endfunction : lfx_decode

  function automatic logic is_sleeping(input pmr_mode_t m);
    return (m == MODE_SLEEP) || (m == MODE_DEEP_SLEEP);
  endfunction : is_sleeping

  // ----------------------------------------
  // Pin synchronisation
  // ----------------------------------------
  logic [PMR_NSYNC-1:0] pins_s;

  pmr_sync #(.W(PMR_NSYNC)) u_sync (
    .MCLK(MCLK),
    .RST(RST),
    .D({WAKE_PAD, CORE_SUPPLY_LOW, CORE_POR, RADIO_RAIL_OK,
        CORE_RAIL_OK, BATT_RAIL_OK, STEPUP_DETECT, ENABLE}),
    .Q(pins_s)
  );

  wire enable_s = pins_s[0];
  wire stepup_s = pins_s[1];
  wire batt_ok_s = pins_s[2];
  wire core_ok_s = pins_s[3];
  wire radio_ok_s = pins_s[4];
  wire por_s = pins_s[5];
  wire supply_low_s = pins_s[6];
  wire wake_s = pins_s[7];

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  pmr_ctrl_t ctrl_reg;
  pmr_mode_t mode_reg;
  pmr_mode_t mode_next;
  logic pready_reg;
  logic [31:0] prdata_reg;
  logic pslverr_reg;
  logic key_armed_reg;
  logic sw_reset_reg;
  logic stepup_reg;
  logic cfg_taken_reg;
  logic [2:0] low_reg;
  logic event_reg;
  logic boot_rest_reg;
  logic from_sleep_reg;
  logic [3:0] cause_reg;

  wire access = PSEL && PENABLE;
  wire first_access = access && !pready_reg;
  wire commit = access && pready_reg;
  wire wr_commit = commit && PWRITE;
  wire sel_ctrl = (PADDR == PMR_OFS_CTRL);
  wire sel_cmd = (PADDR == PMR_OFS_CMD);
  wire sel_swrst = (PADDR == PMR_OFS_SWRST);
  wire sel_status = (PADDR == PMR_OFS_STATUS);
  wire mapped = sel_ctrl || sel_cmd || sel_swrst || sel_status;
  wire wr_swrst = wr_commit && sel_swrst;
  wire cmd_sleep = wr_commit && sel_cmd && PWDATA[PMR_CMD_SLEEP_BIT];
  wire cmd_deep = wr_commit && sel_cmd && PWDATA[PMR_CMD_DEEP_BIT];
  wire key1_hit = (PWDATA == PMR_KEY_FIRST);
  wire key2_hit = key_armed_reg && (PWDATA == PMR_KEY_SECOND);

  wire [31:0] status_word = {16'h0000, cause_reg, 1'b0, low_reg,
                             key_armed_reg, stepup_reg, 3'h0, mode_reg};
  wire [31:0] rd_mux = sel_ctrl ? ctrl_reg :
                       sel_status ? status_word : 32'h0000_0000;

  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      pready_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end
    else
    begin
      pready_reg <= first_access;
      pslverr_reg <= first_access && !mapped;
      if (first_access && !PWRITE)
        prdata_reg <= rd_mux;
    end
  end

  always_ff @(posedge MCLK)
  begin
    if (RST)
      ctrl_reg <= PMR_CTRL_RST;
    else if (wr_commit && sel_ctrl)
      ctrl_reg <= PWDATA & PMR_CTRL_WMASK;
  end

  // ----------------------------------------
  // Software reset key
  // ----------------------------------------
  // A stray write to SWRST drops the armed state; a first key word always re-arms.
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      key_armed_reg <= 1'b0;
      sw_reset_reg <= 1'b0;
    end
    else
    begin
      sw_reset_reg <= wr_swrst && key2_hit;
      if (wr_swrst)
        key_armed_reg <= key1_hit;
    end
  end

  // ----------------------------------------
  // Supply detection and monitoring
  // ----------------------------------------
  // Strap capture and low events wait for the enable pin, so a filling synchroniser is ignored.
  wire [2:0] low_now = {!radio_ok_s, !core_ok_s, !batt_ok_s};

  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      stepup_reg <= 1'b0;
      cfg_taken_reg <= 1'b0;
      low_reg <= 3'h0;
      event_reg <= 1'b0;
    end
    else
    begin
      if (!cfg_taken_reg && enable_s)
      begin
        stepup_reg <= stepup_s;
        cfg_taken_reg <= 1'b1;
      end
      low_reg <= low_now;
      event_reg <= enable_s && |(low_now & ~low_reg);
    end
  end

  // ----------------------------------------
  // Reset sources
  // ----------------------------------------
  wire disabled_now = !enable_s;
  wire core_rst_next = por_s || supply_low_s || WATCHDOG_REQ || sw_reset_reg || disabled_now;

  always_ff @(posedge MCLK)
  begin
    if (RST)
      cause_reg <= 4'h0;
    else if (por_s || supply_low_s || WATCHDOG_REQ || sw_reset_reg)
      cause_reg <= {sw_reset_reg, WATCHDOG_REQ, supply_low_s, por_s};
  end

  // ----------------------------------------
  // Mode state machine
  // ----------------------------------------
  wire sleep_ok = CPU_IDLE && !ctrl_reg.sleep_disable;
  wire want_xtal = RADIO_REQ || XTAL_REQ || from_sleep_reg;
  wire go_sleep = sleep_ok && (ENOUGH_TIME || boot_rest_reg || cmd_sleep);
  wire wake = SLEEP_TIMER_EXPIRED || wake_s;

  always_comb
  begin
    mode_next = mode_reg;
    case (mode_reg)
      MODE_DISABLED:
        mode_next = MODE_ACTIVE_RC;
      MODE_ACTIVE_RC:
        if (cmd_deep)
          mode_next = MODE_DEEP_SLEEP;
        else if (want_xtal)
          mode_next = MODE_ACTIVE_XTAL;
        else if (go_sleep)
          mode_next = MODE_SLEEP;
      MODE_ACTIVE_XTAL:
        if (cmd_deep)
          mode_next = MODE_DEEP_SLEEP;
        else if (!want_xtal)
          mode_next = MODE_ACTIVE_RC;
      MODE_SLEEP, MODE_DEEP_SLEEP:
        if (wake)
          mode_next = MODE_ACTIVE_RC;
      default:
        mode_next = MODE_ACTIVE_RC;
    endcase
    if (disabled_now)
      mode_next = MODE_DISABLED;
  end

  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      mode_reg <= MODE_ACTIVE_RC;
      boot_rest_reg <= 1'b1;
      from_sleep_reg <= 1'b0;
    end
    else
    begin
      mode_reg <= mode_next;
      if (mode_reg == MODE_DISABLED)
        boot_rest_reg <= 1'b1;
      else if (wake_s || is_sleeping(mode_reg))
        boot_rest_reg <= 1'b0;
      if (is_sleeping(mode_reg) && mode_next == MODE_ACTIVE_RC)
        from_sleep_reg <= 1'b1;
      else if (mode_reg == MODE_ACTIVE_XTAL || disabled_now)
        from_sleep_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // Output registers
  // ----------------------------------------
  // Outputs follow the next mode so they change on the same edge as MODE.
  wire n_active = (mode_next == MODE_ACTIVE_RC) || (mode_next == MODE_ACTIVE_XTAL);
  wire n_sleep = is_sleeping(mode_next);
  wire xtal_sleep_clk = ctrl_reg.sleep_clk_xtal && ctrl_reg.cfg_loaded;
  pmr_lfx_t lfx;
  assign lfx = lfx_decode(ctrl_reg.slow_xtal_mode);

  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      MODE <= MODE_ACTIVE_RC;
      CORE_RESET <= 1'b1;
      PADS_HIZ <= 1'b0;
      CPU_POWER_EN <= 1'b1;
      CPU_HALT <= 1'b0;
      CONVERTER_EN <= 1'b1;
      VCC_CHARGE_EN <= 1'b1;
      FAST_RC_EN <= 1'b1;
      XTAL_EN <= 1'b0;
      RETAIN_BANKS <= 3'h0;
      BATT_MON_ON_CORE_RAIL <= 1'b0;
      BATT_THRESH <= 4'h0;
      CORE_THRESH <= PMR_CORE_THRESH_RST;
      RADIO_THRESH_HI <= 1'b0;
      SUPPLY_LOW_EVENT <= 1'b0;
      PMCLK_HALF <= 1'b0;
      PMCLK_FROM_LP_RC <= 1'b1;
      SLOW_RC_TRIM <= 2'h0;
      SLOW_RC_RELAXED <= 1'b0;
      SLOW_RC_CALIB_EN <= 1'b1;
      SLOW_XTAL_AMP_EN <= 1'b0;
      SLOW_XTAL_LOAD_CAP_EN <= 1'b0;
      SLOW_XTAL_CLK_EN <= 1'b0;
    end
    else
    begin
      MODE <= mode_next;
      CORE_RESET <= core_rst_next;
      PADS_HIZ <= (mode_next == MODE_DISABLED);
      CPU_POWER_EN <= n_active;
      CPU_HALT <= n_active && CPU_IDLE && !want_xtal;
      CONVERTER_EN <= n_active;
      VCC_CHARGE_EN <= n_active
        || ((mode_next == MODE_SLEEP) && ctrl_reg.vcc_keep_charged);
      FAST_RC_EN <= (mode_next == MODE_ACTIVE_RC);
      XTAL_EN <= (mode_next == MODE_ACTIVE_XTAL);
      RETAIN_BANKS <= n_sleep ? ctrl_reg.retain_banks : 3'h0;
      BATT_MON_ON_CORE_RAIL <= stepup_reg;
      BATT_THRESH <= ctrl_reg.batt_thresh;
      CORE_THRESH <= ctrl_reg.core_thresh;
      RADIO_THRESH_HI <= ctrl_reg.radio_thresh_hi;
      SUPPLY_LOW_EVENT <= event_reg;
      PMCLK_HALF <= n_sleep;
      PMCLK_FROM_LP_RC <= !n_sleep || xtal_sleep_clk;
      SLOW_RC_TRIM <= ctrl_reg.rc_trim;
      SLOW_RC_RELAXED <= xtal_sleep_clk || (mode_next == MODE_DEEP_SLEEP);
      SLOW_RC_CALIB_EN <= !xtal_sleep_clk;
      SLOW_XTAL_AMP_EN <= lfx.amp_en;
      SLOW_XTAL_LOAD_CAP_EN <= lfx.load_cap_en;
      SLOW_XTAL_CLK_EN <= lfx.clk_en;
    end
  end

  assign PRDATA = prdata_reg;
  assign PREADY = pready_reg;
  assign PSLVERR = pslverr_reg;

endmodule : pmr_ctrl
`default_nettype wire

// *** verification/pmr_ctrl_assertions.sv ***
// Purpose: Concurrent checks on the power mode controller ports.
// Assumes: One clock, MCLK; RST is synchronous and active high.
// Notes: Mode checks wait for a second cycle in the same mode.
`timescale 1ns/100ps
`default_nettype none
module pmr_ctrl_assertions
  import pmr_pkg::*;
(
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST,
  // Pins
  input wire logic ENABLE,
  input wire logic RADIO_RAIL_OK,
  // Mode outputs
  input wire logic [2:0] MODE,
  input wire logic CORE_RESET,
  input wire logic PADS_HIZ,
  input wire logic CONVERTER_EN,
  input wire logic VCC_CHARGE_EN,
  input wire logic FAST_RC_EN,
  input wire logic XTAL_EN,
  // Monitor and clock outputs
  input wire logic SUPPLY_LOW_EVENT,
  input wire logic PMCLK_HALF,
  input wire logic SLOW_RC_RELAXED,
  input wire logic SLOW_XTAL_AMP_EN,
  input wire logic SLOW_XTAL_LOAD_CAP_EN,
  input wire logic SLOW_XTAL_CLK_EN
);
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (RST);
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // Registered outputs change on the same edge as MODE; checks still wait one cycle in the mode.
  AST_DISABLE_ENTRY: assert property ($fell(ENABLE) |-> ##[1:4] MODE == MODE_DISABLED)
    else $error("disable mode not entered");
  AST_DISABLE_STATE: assert property (MODE == MODE_DISABLED
    && $past(MODE) == MODE_DISABLED |-> PADS_HIZ && CORE_RESET)
    else $error("disabled without float or reset");
  AST_ACTIVE_RC: assert property (MODE == MODE_ACTIVE_RC && $past(MODE) == MODE_ACTIVE_RC
    |-> FAST_RC_EN && CONVERTER_EN && !PMCLK_HALF) else $error("active rc outputs wrong");
  AST_ACTIVE_XTAL: assert property (MODE == MODE_ACTIVE_XTAL
    && $past(MODE) == MODE_ACTIVE_XTAL |-> XTAL_EN && CONVERTER_EN)
    else $error("active xtal outputs wrong");
  AST_SLEEP: assert property (MODE == MODE_SLEEP && $past(MODE) == MODE_SLEEP
    |-> PMCLK_HALF && !CONVERTER_EN && !FAST_RC_EN) else $error("sleep outputs wrong");
  AST_DEEP: assert property (MODE == MODE_DEEP_SLEEP && $past(MODE) == MODE_DEEP_SLEEP
    |-> !VCC_CHARGE_EN && SLOW_RC_RELAXED && PMCLK_HALF) else $error("deep outputs wrong");
  AST_WAKE_TO_RC: assert property ($past(MODE) inside {MODE_SLEEP, MODE_DEEP_SLEEP,
    MODE_DISABLED} && MODE != $past(MODE) && MODE != MODE_DISABLED |-> MODE == MODE_ACTIVE_RC)
    else $error("wake did not enter active rc");
  AST_RADIO_LOW_EVENT: assert property ($fell(RADIO_RAIL_OK) |-> ##[2:5] SUPPLY_LOW_EVENT)
    else $error("no event on low radio rail");
  AST_SLOW_XTAL_MODES: assert property (SLOW_XTAL_AMP_EN || SLOW_XTAL_LOAD_CAP_EN
    |-> SLOW_XTAL_CLK_EN && (SLOW_XTAL_AMP_EN || !SLOW_XTAL_LOAD_CAP_EN))
    else $error("slow xtal enables inconsistent");
  COV_SLEEP: cover property (MODE == MODE_SLEEP);
  COV_DEEP: cover property (MODE == MODE_DEEP_SLEEP);
  COV_XTAL: cover property (MODE == MODE_ACTIVE_XTAL);
endmodule : pmr_ctrl_assertions
bind pmr_ctrl pmr_ctrl_assertions pmr_ctrl_assertions_inst (.*);
`default_nettype wire

// *** verification/pmr_fw.sv ***
// Purpose: Firmware side model, an APB master with one transfer task.
// Assumes: The slave raises PREADY in its own time; only the bench timeout ends a wait.
// Notes: Released address and data show the inverse of the last value.
`timescale 1ns/100ps
`default_nettype none
module pmr_fw
(
  // Clock
  input wire logic MCLK,
  // APB master
  output var logic PSEL,
  output var logic PENABLE,
  output var logic PWRITE,
  output var logic [7:0] PADDR,
  output var logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR
);
  initial
  begin
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 8'h00;
    PWDATA = 32'h0;
  end
  // Key words and commands are sent by the bench through this task.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic e);
    @(posedge MCLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge MCLK);
    PENABLE <= 1'b1;
    @(posedge MCLK);
    while (PREADY !== 1'b1)
    begin
      @(posedge MCLK);
    end
    q = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    PADDR <= ~a;
    PWDATA <= ~d;
  endtask : xfer
endmodule : pmr_fw
`default_nettype wire

// *** verification/tb_top.sv ***
// Purpose: Self-checking bench for the power mode and reset controller.
// Assumes: Random register data from a fixed seed; pins driven on MCLK.
// Notes: Reset pulses are counted on rising edges; supply events are counted per cycle high.
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import pmr_pkg::*;
;
  logic MCLK = 0, RST = 1, ENABLE = 1, STEPUP_DETECT = 1, BATT_RAIL_OK = 1;
  logic CORE_RAIL_OK = 1, RADIO_RAIL_OK = 1, CORE_POR = 0, CORE_SUPPLY_LOW = 0;
  logic WAKE_PAD = 0, WATCHDOG_REQ = 0, RADIO_REQ = 0, XTAL_REQ = 0, CPU_IDLE = 0;
  logic ENOUGH_TIME = 0, SLEEP_TIMER_EXPIRED = 0, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
  logic [7:0] PADDR;
  logic [31:0] PWDATA, PRDATA, w, q, r0;
  logic [2:0] MODE, RETAIN_BANKS;
  logic [3:0] BATT_THRESH, CORE_THRESH;
  logic [1:0] SLOW_RC_TRIM;
  logic CORE_RESET, PADS_HIZ, CPU_POWER_EN, CPU_HALT, CONVERTER_EN, VCC_CHARGE_EN;
  logic FAST_RC_EN, XTAL_EN, BATT_MON_ON_CORE_RAIL, RADIO_THRESH_HI, SUPPLY_LOW_EVENT;
  logic PMCLK_HALF, PMCLK_FROM_LP_RC, SLOW_RC_RELAXED, SLOW_RC_CALIB_EN, e, crst_d = 0;
  logic SLOW_XTAL_AMP_EN, SLOW_XTAL_LOAD_CAP_EN, SLOW_XTAL_CLK_EN;
  int n_errors = 0, cmp_count = 0, cycles = 0, rises = 0, events = 0, seed = 75, i, k;
  pmr_ctrl pmr_ctrl_inst (.*);
  pmr_fw pmr_fw_inst (.*);
  always #12.5 MCLK = ~MCLK;
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task end_sim;
    $display("Mismatches %0d, comparisons %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_sim
  task chk(input string nm, input logic [31:0] x, input logic [31:0] s);
    cmp_count++;
    if (s !== x)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, x, s);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [31:0] d);
    pmr_fw_inst.xfer(1'b1, a, d, q, e);
  endtask : wr
  task wait_mode(input logic [2:0] m);
    for (int n = 0; n < 40 && MODE !== m; n++)
      @(posedge MCLK);
    chk("mode", m, MODE);
  endtask : wait_mode
  // The expected enables are ordered amplifier, load capacitor, clock.
  function logic [2:0] lfx(input logic [1:0] m);
    return {m[0], m == 2'h1, m != 2'h0};
  endfunction : lfx
  always @(posedge MCLK)
  begin
    cycles++;
    if (CORE_RESET === 1'b1 && crst_d === 1'b0)
      rises++;
    crst_d <= CORE_RESET;
    if (SUPPLY_LOW_EVENT === 1'b1)
      events++;
    if (cycles == 20000)
    begin
      n_errors++;
      end_sim;
    end
  end
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial
  begin
    repeat (5) @(posedge MCLK);
    RST <= 1'b0;
    // The pin synchroniser reads the enable pin low for two edges after release.
    repeat (2) @(posedge MCLK);
    chk("boot_mode", MODE_DISABLED, MODE);
    repeat (3) @(posedge MCLK);
    wait_mode(MODE_ACTIVE_RC);
    chk("active_out", 32'h7, {CPU_POWER_EN, FAST_RC_EN, CONVERTER_EN});
    chk("stepup", 1, BATT_MON_ON_CORE_RAIL);
    chk("core_th", PMR_CORE_THRESH_RST, CORE_THRESH);
    chk("calib", 1, SLOW_RC_CALIB_EN);
    pmr_fw_inst.xfer(1'b0, PMR_OFS_CTRL, 32'h0, q, e);
    chk("ctrl", PMR_CTRL_RST, q);
    pmr_fw_inst.xfer(1'b0, 8'h10, 32'h0, q, e);
    chk("slverr", 32'h1, {31'h0, e});
    chk("rd_unmapped", 32'h0, q);
    for (i = 0; i < 8; i++)
    begin
      w = $random(seed);
      if (i < 4)
        w[13:12] = i[1:0];
      wr(PMR_OFS_CTRL, w);
      pmr_fw_inst.xfer(1'b0, PMR_OFS_CTRL, 32'h0, q, e);
      chk("ctrl", w & PMR_CTRL_WMASK, q);
      chk("batt_th", w[3:0], BATT_THRESH);
      chk("core_th", w[7:4], CORE_THRESH);
      chk("radio_th", w[8], RADIO_THRESH_HI);
      chk("trim", {1'b1, w[17:16]}, {PMCLK_FROM_LP_RC, SLOW_RC_TRIM});
      chk("lfx", lfx(w[13:12]),
        {SLOW_XTAL_AMP_EN, SLOW_XTAL_LOAD_CAP_EN, SLOW_XTAL_CLK_EN});
      chk("calib", !(w[11] && w[14]), SLOW_RC_CALIB_EN);
      chk("relax", w[11] && w[14], SLOW_RC_RELAXED);
    end
    r0 = rises;
    wr(PMR_OFS_SWRST, PMR_KEY_FIRST);
    wr(PMR_OFS_SWRST, 32'h0);
    wr(PMR_OFS_SWRST, PMR_KEY_SECOND);
    repeat (4) @(posedge MCLK);
    chk("swrst_broken", r0, rises);
    wr(PMR_OFS_SWRST, PMR_KEY_FIRST);
    wr(PMR_OFS_SWRST, PMR_KEY_SECOND);
    repeat (4) @(posedge MCLK);
    chk("swrst", r0 + 1, rises);
    pmr_fw_inst.xfer(1'b0, PMR_OFS_STATUS, 32'h0, q, e);
    chk("status", 32'h0000_8040, q);
    for (k = 0; k < 3; k++)
    begin
      r0 = rises;
      {WATCHDOG_REQ, CORE_POR, CORE_SUPPLY_LOW} <= 3'h4 >> k;
      repeat (4) @(posedge MCLK);
      {WATCHDOG_REQ, CORE_POR, CORE_SUPPLY_LOW} <= 3'h0;
      repeat (6) @(posedge MCLK);
      chk("rst_src", r0 + 1, rises);
    end
    wr(PMR_OFS_CTRL, 32'h001c_0420);
    for (k = 0; k < 2; k++)
    begin
      wait_mode(MODE_ACTIVE_RC);
      {RADIO_REQ, XTAL_REQ} <= 2'h2 >> k;
      wait_mode(MODE_ACTIVE_XTAL);
      {RADIO_REQ, XTAL_REQ} <= 2'h0;
    end
    wait_mode(MODE_ACTIVE_RC);
    CPU_IDLE <= 1'b1;
    wait_mode(MODE_SLEEP);
    chk("sleep_out", 5'h1e, {VCC_CHARGE_EN, RETAIN_BANKS, CONVERTER_EN});
    chk("sleep_cpu", 0, CPU_POWER_EN);
    SLEEP_TIMER_EXPIRED <= 1'b1;
    CPU_IDLE <= 1'b0;
    wait_mode(MODE_ACTIVE_RC);
    SLEEP_TIMER_EXPIRED <= 1'b0;
    wait_mode(MODE_ACTIVE_XTAL);
    wait_mode(MODE_ACTIVE_RC);
    CPU_IDLE <= 1'b1;
    repeat (6) @(posedge MCLK);
    chk("idle_halt", {MODE_ACTIVE_RC, 1'b1}, {MODE, CPU_HALT});
    ENOUGH_TIME <= 1'b1;
    wait_mode(MODE_SLEEP);
    WAKE_PAD <= 1'b1;
    CPU_IDLE <= 1'b0;
    wait_mode(MODE_ACTIVE_RC);
    WAKE_PAD <= 1'b0;
    wr(PMR_OFS_CTRL, 32'h0000_0620);
    CPU_IDLE <= 1'b1;
    repeat (8) @(posedge MCLK);
    chk("sleep_off", {MODE_ACTIVE_RC, 1'b1}, {MODE, CPU_HALT});
    CPU_IDLE <= 1'b0;
    ENOUGH_TIME <= 1'b0;
    wr(PMR_OFS_CTRL, PMR_CTRL_RST);
    wr(PMR_OFS_CMD, 32'h2);
    wait_mode(MODE_DEEP_SLEEP);
    chk("deep_out", 3'h3, {VCC_CHARGE_EN, SLOW_RC_RELAXED, PMCLK_HALF});
    WAKE_PAD <= 1'b1;
    wait_mode(MODE_ACTIVE_RC);
    WAKE_PAD <= 1'b0;
    CPU_IDLE <= 1'b1;
    repeat (6) @(posedge MCLK);
    chk("no_sleep", MODE_ACTIVE_RC, MODE);
    wr(PMR_OFS_CMD, 32'h1);
    wait_mode(MODE_SLEEP);
    WAKE_PAD <= 1'b1;
    CPU_IDLE <= 1'b0;
    wait_mode(MODE_ACTIVE_RC);
    WAKE_PAD <= 1'b0;
    for (k = 0; k < 3; k++)
    begin
      r0 = events;
      {BATT_RAIL_OK, CORE_RAIL_OK, RADIO_RAIL_OK} <= ~(3'h1 << k);
      repeat (6) @(posedge MCLK);
      {BATT_RAIL_OK, CORE_RAIL_OK, RADIO_RAIL_OK} <= 3'h7;
      repeat (4) @(posedge MCLK);
      chk("low_event", r0 + 1, events);
    end
    ENABLE <= 1'b0;
    wait_mode(MODE_DISABLED);
    chk("hiz", 2'h3, {PADS_HIZ, CORE_RESET});
    CPU_IDLE <= 1'b1;
    ENABLE <= 1'b1;
    wait_mode(MODE_ACTIVE_RC);
    wait_mode(MODE_SLEEP);
    end_sim;
  end
endmodule : tb_top
`default_nettype wire
